// >>> rtl/err_status_pkg.sv
// Package of constants and types for the instrument error status block
package err_status_pkg;

   // Error code class boundaries (decimal error codes)
   localparam logic [6:0] MEAS_FIRST     = 7'h01;
   localparam logic [6:0] MEAS_LAST      = 7'h31;   // 49
   localparam logic [6:0] ENTRY_A_FIRST  = 7'h32;   // 50
   localparam logic [6:0] ENTRY_A_LAST   = 7'h3B;   // 59
   localparam logic [6:0] SERVICE_FIRST  = 7'h3C;   // 60
   localparam logic [6:0] SERVICE_LAST   = 7'h4F;   // 79
   localparam logic [6:0] ENTRY_B_FIRST  = 7'h50;   // 80
   localparam logic [6:0] ENTRY_B_LAST   = 7'h63;   // 99
   localparam logic [6:0] CODE_MEM_LOST  = 7'h39;   // 57
   localparam logic [6:0] CODE_NO_TABLE  = 7'h50;   // 80

   // Error-coded talk value: characters "9.00", two BCD digits, "E+40"
   localparam logic [3:0] TALK_LEAD_DIGIT = 4'h9;
   localparam logic [3:0] TALK_EXP_TENS   = 4'h4;
   localparam logic [3:0] TALK_EXP_UNITS  = 4'h0;

   // Reset values
   localparam logic [7:0] CODE_BCD_RESET  = 8'h00;

   // Hold time of the memory-lost indication
   localparam int unsigned CLK_HZ         = 40_000_000;
   localparam int unsigned MEM_LOST_MS    = 2000;
   localparam int unsigned MEM_LOST_CYC   = (CLK_HZ / 1000) * MEM_LOST_MS;

   // Error class encoding, one-hot
   typedef enum logic [3:0] {
      CLS_NONE    = 4'b0001,
      CLS_MEAS    = 4'b0010,
      CLS_ENTRY   = 4'b0100,
      CLS_SERVICE = 4'b1000
   } err_class_type;

   // Memory-lost indication sequencer, one-hot
   typedef enum logic [2:0] {
      ML_IDLE   = 3'b001,
      ML_SHOW   = 3'b010,
      ML_PRESET = 3'b100
   } mem_lost_state_type;

endpackage

// >>> rtl/err_code_class.sv
// Error code classifier, display filter and binary to BCD conversion
module err_code_class
   import err_status_pkg::*;
(
   input  wire logic [6:0]   code,
   output err_class_type     err_class,
   output logic              shows_display,
   output logic [7:0]        code_bcd
);

   // Class by code range; codes 0 and above 99 are not errors
   always_comb begin
      if (code >= MEAS_FIRST && code <= MEAS_LAST) begin
         err_class = CLS_MEAS;
      end else if ((code >= ENTRY_A_FIRST && code <= ENTRY_A_LAST) ||
                   (code >= ENTRY_B_FIRST && code <= ENTRY_B_LAST)) begin
         err_class = CLS_ENTRY;
      end else if (code >= SERVICE_FIRST && code <= SERVICE_LAST) begin
         err_class = CLS_SERVICE;
      end else begin
         err_class = CLS_NONE;
      end
   end

   assign shows_display = (code >= MEAS_FIRST && code <= MEAS_LAST) ||
                          (code == CODE_MEM_LOST) || (code == CODE_NO_TABLE);

   // Two-digit decimal form; only codes up to 99 are meaningful here
   logic [6:0] tens;
   logic [6:0] units;
   assign tens  = code / 7'd10;
   assign units = code - tens * 7'd10;
   assign code_bcd = {tens[3:0], units[3:0]};

endmodule

// >>> rtl/instrument_error_status.sv
// Error status, display selection and error-coded talk output of a power meter
module instrument_error_status
   import err_status_pkg::*;
#(
   parameter int unsigned MEM_LOST_CYCLES = MEM_LOST_CYC
)
(
   input  wire logic         core_clk,
   input  wire logic         rstn,
   input  wire logic         err_valid,
   input  wire logic [6:0]   err_code,
   input  wire logic         err_active,
   input  wire logic         srq_mask_meas,
   input  wire logic         srq_mask_entry,
   input  wire logic         talk_req,
   input  wire logic         read_status_message_cmd,
   input  wire logic         function_select,
   output logic              err_is_meas,
   output logic              err_is_entry,
   output logic              err_is_service,
   output logic              display_on,
   output logic [7:0]        display_code,
   output logic              talk_valid,
   output logic              talk_is_error,
   output logic [39:0]       talk_error_value,
   output logic              status_latched,
   output logic              rqs,
   output logic [7:0]        status_code,
   output logic              preset_pulse
);

   ////////////////////////////////////////////////////////////////////////
   // Classification of the incoming code

   err_class_type in_class;
   logic          in_display;
   logic [7:0]    in_bcd;

   err_code_class u_class (
      .code          (err_code),
      .err_class     (in_class),
      .shows_display (in_display),
      .code_bcd      (in_bcd)
   );

   logic in_meas;
   logic in_entry;
   logic in_srq;
   assign in_meas  = err_valid && (in_class == CLS_MEAS);
   assign in_entry = err_valid && (in_class == CLS_ENTRY);
   assign in_srq   = (in_meas && srq_mask_meas) || (in_entry && srq_mask_entry);

   ////////////////////////////////////////////////////////////////////////
   // Class outputs of the last reported code

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         err_is_meas    <= 1'b0;
         err_is_entry   <= 1'b0;
         err_is_service <= 1'b0;
      end else if (err_valid) begin
         err_is_meas    <= (in_class == CLS_MEAS);
         err_is_entry   <= (in_class == CLS_ENTRY);
         err_is_service <= (in_class == CLS_SERVICE);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Display: measurement errors stay up while the cause persists

   logic                disp_r;
   logic [7:0]          disp_code_r;
   logic                disp_meas_r;
   mem_lost_state_type  ml_state_r;
   logic [31:0]         ml_count_r;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         disp_r      <= 1'b0;
         disp_code_r <= CODE_BCD_RESET;
         disp_meas_r <= 1'b0;
      end else if (err_valid && in_display) begin
         disp_r      <= 1'b1;
         disp_code_r <= in_bcd;
         disp_meas_r <= (in_class == CLS_MEAS);
      end else if (disp_meas_r && !err_active) begin
         disp_r      <= 1'b0;
         disp_meas_r <= 1'b0;
      end else if (!disp_meas_r && disp_r && ml_state_r == ML_PRESET) begin
         disp_r <= 1'b0;
      end else if (!disp_meas_r && disp_r && disp_code_r != 8'h57) begin
         // Code 80 stays shown while err_active holds and goes off once it clears
         disp_r <= err_active;
      end
   end

   assign display_on   = disp_r;
   assign display_code = disp_code_r;

   ////////////////////////////////////////////////////////////////////////
   // Memory-lost indication: timeout or a function key ends it

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ml_state_r <= ML_IDLE;
         ml_count_r <= 32'h0000_0000;
      end else begin
         case (ml_state_r)
            ML_IDLE: begin
               ml_count_r <= 32'h0000_0000;
               if (err_valid && err_code == CODE_MEM_LOST) begin
                  ml_state_r <= ML_SHOW;
               end
            end
            ML_SHOW: begin
               ml_count_r <= ml_count_r + 32'h0000_0001;
               if (function_select || ml_count_r >= MEM_LOST_CYCLES - 1) begin
                  ml_state_r <= ML_PRESET;
               end
            end
            ML_PRESET: begin
               ml_state_r <= ML_IDLE;
            end
            default: begin
               ml_state_r <= ML_IDLE;
            end
         endcase
      end
   end

   assign preset_pulse = (ml_state_r == ML_PRESET);

   ////////////////////////////////////////////////////////////////////////
   // Talk output: registered answer one cycle after the talk request

   logic meas_shown;
   assign meas_shown = disp_r && disp_meas_r;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         talk_valid       <= 1'b0;
         talk_is_error    <= 1'b0;
         talk_error_value <= 40'h00_0000_0000;
      end else begin
         talk_valid    <= talk_req;
         talk_is_error <= talk_req && meas_shown;
         if (talk_req && meas_shown) begin
            talk_error_value <= {TALK_LEAD_DIGIT, 4'h0, 4'h0, disp_code_r,
                                 4'hE, 4'hA, TALK_EXP_TENS, TALK_EXP_UNITS,
                                 4'h0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status byte and status message latch

   logic latch_set;
   logic cause_gone;
   logic sent_meas;
   // A talk request while a measurement error is shown puts the coded value on the bus
   assign sent_meas  = talk_req && meas_shown;
   assign latch_set  = in_srq || in_entry || sent_meas;
   assign cause_gone = !err_active;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         status_latched <= 1'b0;
         rqs            <= 1'b0;
         status_code    <= CODE_BCD_RESET;
      end else if (latch_set) begin
         // newest code wins; set beats a same-cycle clear
         status_latched <= 1'b1;
         rqs            <= rqs || in_srq;
         status_code    <= (in_srq || in_entry) ? in_bcd : disp_code_r;
      end else if (read_status_message_cmd && cause_gone) begin
         status_latched <= 1'b0;
         rqs            <= 1'b0;
         status_code    <= CODE_BCD_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   // rejected entry stays latched until read
   sequence s_entry_in;
      in_entry && !in_srq;
   endsequence

   // Measurement error that is neither requested nor sent this cycle
   sequence s_meas_quiet;
      in_meas && !srq_mask_meas && !talk_req && !status_latched;
   endsequence

   a_entry_latches: assert property (@(posedge core_clk) disable iff (!rstn)
      s_entry_in |=> status_latched && status_code == $past(in_bcd))
      else $error("entry error not latched");

   a_srq_latches: assert property (@(posedge core_clk) disable iff (!rstn)
      in_srq |=> rqs && status_latched)
      else $error("requested error not latched");

   a_mask_blocks: assert property (@(posedge core_clk) disable iff (!rstn)
      (!rqs && !in_srq) |=> !rqs)
      else $error("request raised while masked");

   a_hold_active: assert property (@(posedge core_clk) disable iff (!rstn)
      (status_latched && err_active && !latch_set) |=> status_latched)
      else $error("latch cleared while cause present");

   a_read_clears: assert property (@(posedge core_clk) disable iff (!rstn)
      (read_status_message_cmd && !err_active && !latch_set) |=> !status_latched)
      else $error("latch not cleared by read");

   a_meas_sent: assert property (@(posedge core_clk) disable iff (!rstn)
      (meas_shown && talk_req && !status_latched) |=> status_latched)
      else $error("sent measurement error not latched");

   a_talk_code: assert property (@(posedge core_clk) disable iff (!rstn)
      (talk_req && meas_shown) |=> talk_is_error &&
         talk_error_value[27:20] == $past(disp_code_r))
      else $error("talk value lacks error code");

   a_newest_code: assert property (@(posedge core_clk) disable iff (!rstn)
      (in_entry) |=> status_code == $past(in_bcd))
      else $error("status message not newest code");

   a_meas_class: assert property (@(posedge core_clk) disable iff (!rstn)
      (err_valid && err_code >= MEAS_FIRST && err_code <= MEAS_LAST) |=> err_is_meas)
      else $error("code not classed as measurement");

   a_svc_class: assert property (@(posedge core_clk) disable iff (!rstn)
      (err_valid && err_code >= SERVICE_FIRST && err_code <= SERVICE_LAST) |=> err_is_service)
      else $error("code not classed as service");

   a_entry_class: assert property (@(posedge core_clk) disable iff (!rstn)
      (err_valid && err_code >= ENTRY_B_FIRST && err_code <= ENTRY_B_LAST) |=> err_is_entry)
      else $error("code not classed as entry");

   a_entry_low: assert property (@(posedge core_clk) disable iff (!rstn)
      (err_valid && err_code >= ENTRY_A_FIRST && err_code <= ENTRY_A_LAST) |=> err_is_entry)
      else $error("low entry code not classed as entry");

   a_hidden_code: assert property (@(posedge core_clk) disable iff (!rstn)
      (err_valid && !in_display && !display_on) |=> !display_on)
      else $error("unlisted code shown on display");

   a_talk_plain: assert property (@(posedge core_clk) disable iff (!rstn)
      (talk_req && !meas_shown) |=> talk_valid && !talk_is_error)
      else $error("plain talk marked as error value");

   a_talk_once: assert property (@(posedge core_clk) disable iff (!rstn)
      !talk_req |=> !talk_valid)
      else $error("talk answer without a request");

   a_meas_unsent: assert property (@(posedge core_clk) disable iff (!rstn)
      s_meas_quiet |=> !status_latched)
      else $error("unsent measurement error latched");

   a_rqs_latched: assert property (@(posedge core_clk) disable iff (!rstn)
      rqs |-> status_latched)
      else $error("request bit without latched error");

   a_code_held: assert property (@(posedge core_clk) disable iff (!rstn)
      (status_latched && !latch_set && !read_status_message_cmd) |=> $stable(status_code))
      else $error("latched code changed without a new error");

   a_preset_source: assert property (@(posedge core_clk) disable iff (!rstn)
      preset_pulse |-> $past(ml_state_r) == ML_SHOW)
      else $error("preset without memory-lost indication");

   a_display_pick: assert property (@(posedge core_clk) disable iff (!rstn)
      (err_valid && err_code == CODE_MEM_LOST) |=> display_on && display_code == 8'h57)
      else $error("code 57 not displayed");

   a_mem_lost_key: assert property (@(posedge core_clk) disable iff (!rstn)
      (ml_state_r == ML_SHOW && function_select) |=> preset_pulse ##1 !preset_pulse)
      else $error("memory-lost not ended by function key");

   a_bcd_form: assert property (@(posedge core_clk) disable iff (!rstn)
      (err_valid && err_code == 7'h58) |-> in_bcd == 8'h88)
      else $error("code not held as decimal digits");

endmodule

// >>> sim/gpib_ctl_model.sv
// Bus controller model that addresses the meter to talk and reads its status message
module gpib_ctl_model
(
   input  wire logic core_clk,
   output logic      talk_req,
   output logic      read_status_message_cmd
);
   timeunit 1ns;
   timeprecision 100ps;

   // Both strobes idle low; the controller never holds one across two requests
   initial begin
      talk_req = 1'b0;
      read_status_message_cmd = 1'b0;
   end

   // fresh entry each time
   // A rejected entry is never replayed; every request is a new one-cycle strobe
   task automatic send_talk();
      @(posedge core_clk);
      #2 talk_req = 1'b1;
      @(posedge core_clk);
      #2 talk_req = 1'b0;
   endtask

   // read clears latch
   // Reading is the only way the controller releases a latched error
   task automatic send_read();
      @(posedge core_clk);
      #2 read_status_message_cmd = 1'b1;
      @(posedge core_clk);
      #2 read_status_message_cmd = 1'b0;
   endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench of the error status block against an integer reference model
module tb;
   import err_status_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned ML_CYC = 10; // Short memory-lost hold keeps the run brief
   logic        core_clk, rstn, err_valid, err_active, function_select;
   logic        srq_mask_meas, srq_mask_entry, talk_req, read_status_message_cmd;
   logic [6:0]  err_code;
   logic        err_is_meas, err_is_entry, err_is_service, display_on, talk_valid;
   logic        talk_is_error, status_latched, rqs, preset_pulse;
   logic [7:0]  display_code, status_code;
   logic [39:0] talk_error_value;
   logic [31:0] seed;
   int          fails, comparisons, m_lat, m_rqs, m_code, m_shown, c, n;
   int          bnd[12] = '{0, 1, 49, 50, 57, 59, 60, 79, 80, 99, 11, 33};

   instrument_error_status #(.MEM_LOST_CYCLES(ML_CYC)) instrument_error_status_i (.*);
   gpib_ctl_model gpib_ctl_model_i (.core_clk(core_clk), .talk_req(talk_req),
      .read_status_message_cmd(read_status_message_cmd));

   // Free-running clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] to_bcd(input int v);
      return {4'(v / 10), 4'(v % 10)};
   endfunction
   // Class as {meas, entry, service}; codes outside 1..99 have no class
   function automatic logic [2:0] cls_of(input int k);
      if (k >= 1 && k <= 49) return 3'b100;
      if ((k >= 50 && k <= 59) || (k >= 80 && k <= 99)) return 3'b010;
      if (k >= 60 && k <= 79) return 3'b001;
      return 3'b000;
   endfunction
   function automatic logic shows(input int k);
      return (k >= 1 && k <= 49) || k == 57 || k == 80;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_val(input logic [39:0] got, input logic [39:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk_status();
      chk_bit(status_latched, m_lat != 0);
      chk_bit(rqs, m_rqs != 0);
      if (m_lat != 0) chk_val(40'(status_code), 40'(to_bcd(m_code)));
   endtask
   task automatic do_reset();
      rstn = 1'b0;
      m_lat = 0;
      m_rqs = 0;
      m_code = 0;
      m_shown = 0;
      repeat (6) @(posedge core_clk);
      #2 rstn = 1'b1;
   endtask
   // One error report; the model latches per class and mask
   task automatic raise(input int k);
      @(posedge core_clk);
      #2;
      err_valid = 1'b1;
      err_code = 7'(k);
      @(posedge core_clk);
      #2 err_valid = 1'b0;
      if (cls_of(k) == 3'b010) begin
         m_lat = 1;
         m_code = k;
         m_rqs = m_rqs | int'(srq_mask_entry);
      end
      if (cls_of(k) == 3'b100) begin
         m_shown = k;
         if (srq_mask_meas) begin
            m_lat = 1;
            m_code = k;
            m_rqs = 1;
         end
      end
   endtask
   task automatic talk();
      gpib_ctl_model_i.send_talk();
      chk_bit(talk_valid, 1'b1);
      chk_bit(talk_is_error, m_shown != 0);
      if (m_shown != 0) begin
         chk_val(talk_error_value, {12'h900, to_bcd(m_shown), 20'hEA400});
         m_lat = 1;
         m_code = m_shown;
      end
   endtask
   task automatic read_sm();
      gpib_ctl_model_i.send_read();
      if (err_active === 1'b0) begin
         m_lat = 0;
         m_rqs = 0;
         m_shown = 0;
      end
      chk_status();
   endtask
   task automatic wait_preset(input int lo, input int hi);
      n = 0;
      while (preset_pulse !== 1'b1 && n < hi + 2) begin
         @(posedge core_clk);
         #2 n++;
      end
      chk_bit(n >= lo && n <= hi, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog: a hang counts as a mismatch and ends the run
   initial begin
      #(25 * 20000);
      fails++;
      end_of_test();
   end

   initial begin
      {err_valid, err_active, function_select, srq_mask_meas, srq_mask_entry} = '0;
      err_code = 7'h00;
      fails = 0;
      comparisons = 0;
      seed = 32'h965A;
      do_reset();
      err_active = 1'b1;
      // Class and display per code, boundaries first, then random codes and masks
      for (int i = 0; i < 30; i++) begin
         c = (i < 12) ? bnd[i] : int'(next_rand() % 100);
         srq_mask_meas = 1'(next_rand() % 2);
         srq_mask_entry = 1'(next_rand() % 2);
         do_reset();
         raise(c);
         chk_val(40'({err_is_meas, err_is_entry, err_is_service}), 40'(cls_of(c)));
         chk_bit(display_on, shows(c));
         if (shows(c)) chk_val(40'(display_code), 40'(to_bcd(c)));
         chk_status();
      end
      // Unrequested entry error; a read is refused while its cause remains
      do_reset();
      talk();
      srq_mask_meas = 1'b0;
      srq_mask_entry = 1'b0;
      raise(52);
      chk_status();
      read_sm();
      err_active = 1'b0;
      read_sm();
      // Back-to-back requested entry errors keep the most recent code
      err_active = 1'b1;
      srq_mask_entry = 1'b1;
      raise(85);
      raise(51);
      chk_status();
      err_active = 1'b0;
      read_sm();
      // Unrequested measurement error latches only once sent
      err_active = 1'b1;
      srq_mask_entry = 1'b0;
      raise(11);
      chk_status();
      talk();
      chk_status();
      err_active = 1'b0;
      read_sm();
      // Requested measurement error sets the request bit at once
      err_active = 1'b1;
      srq_mask_meas = 1'b1;
      raise(23);
      chk_status();
      talk();
      // Memory-lost indication ends by timeout, then by a function key
      do_reset();
      raise(57);
      wait_preset(ML_CYC - 2, ML_CYC + 1);
      raise(57);
      @(posedge core_clk);
      #2 function_select = 1'b1;
      @(posedge core_clk);
      #2 function_select = 1'b0;
      wait_preset(0, 2);
      end_of_test();
   end
endmodule
